// ---- hdl/ddt_pkg.sv ----
// Constants and carrier types for the dither and offset trim register bank.
// Assumes one system clock and an internal register port on that clock.
package ddt_pkg;

  // ***************************************************************************
  // Register map and reset values
  // ***************************************************************************
  localparam logic [7:0] OFS_RIGHT_SECONDARY_DC_DITHER  = 8'h4C;
  localparam logic [7:0] OFS_LEFT_DC_OFFSET_TRIM        = 8'h4E;
  localparam logic [7:0] OFS_RIGHT_DC_OFFSET_TRIM       = 8'h4F;
  localparam logic [7:0] OFS_SERIAL_OUT_PIN_SOURCE_SEL  = 8'h55;

  localparam logic [7:0] RST_RIGHT_SECONDARY_DC_DITHER  = 8'h00;
  localparam logic [7:0] RST_LEFT_DC_OFFSET_TRIM        = 8'h00;
  localparam logic [7:0] RST_RIGHT_DC_OFFSET_TRIM       = 8'h00;
  localparam logic [7:0] RST_SERIAL_OUT_PIN_SOURCE_SEL  = 8'h00;

  // ***************************************************************************
  // Field layout
  // ***************************************************************************
  localparam int         PIN_SOURCE_LSB   = 0;
  localparam int         PIN_SOURCE_WIDTH = 5;
  localparam int         DITHER_WIDTH     = 11;
  localparam int         TRIM_WIDTH       = 9;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;

  // ***************************************************************************
  // Carrier types
  // ***************************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ddt_req_s;

  typedef struct packed {
    logic [7:0]                    dither;
    logic [7:0]                    left_trim;
    logic [7:0]                    right_trim;
    logic [7:0]                    pin_source;
    logic [7:0]                    rdata;
    logic                          rvalid;
    logic [DITHER_WIDTH-1:0]       dither_addend;
    logic signed [TRIM_WIDTH-1:0]  left_offset;
    logic signed [TRIM_WIDTH-1:0]  right_offset;
  } ddt_state_s;

  localparam ddt_state_s STATE_RESET = '{
    dither:        RST_RIGHT_SECONDARY_DC_DITHER,
    left_trim:     RST_LEFT_DC_OFFSET_TRIM,
    right_trim:    RST_RIGHT_DC_OFFSET_TRIM,
    pin_source:    RST_SERIAL_OUT_PIN_SOURCE_SEL,
    rdata:         8'h00,
    rvalid:        1'b0,
    dither_addend: '0,
    left_offset:   '0,
    right_offset:  '0
  };

endpackage : ddt_pkg

// ---- hdl/ddt_regs.sv ----
// Register bank for the right secondary DC dither, the two DAC offset trims
// and the serial output pin source selection.
// Assumes the control port decoder drives single-cycle strobes on REF_CLK.
// Assumes REG_REQ comes from logic on REF_CLK, so it is not synchronised.
// The outputs feed modulator and offset stages in the same clock domain.
`timescale 1ns/1ps

module ddt_regs (
  input  wire logic                                   REF_CLK,
  input  wire logic                                   RST_N,
  input  wire ddt_pkg::ddt_req_s                      REG_REQ,
  output logic        [7:0]                           REG_RDATA,
  output logic                                        REG_RVALID,
  output logic        [ddt_pkg::DITHER_WIDTH-1:0]     RIGHT_SEC_LOWER_DITHER,
  output logic signed [ddt_pkg::TRIM_WIDTH-1:0]       LEFT_OFFSET_QMV,
  output logic signed [ddt_pkg::TRIM_WIDTH-1:0]       RIGHT_OFFSET_QMV,
  output logic        [ddt_pkg::PIN_SOURCE_WIDTH-1:0] SERIAL_OUT_SOURCE_SEL
);

  // ***************************************************************************
  // Register map
  // ***************************************************************************
  // Offset 0x4C holds the right secondary DC dither code, unsigned.
  // Offset 0x4E holds the left DAC offset trim code, two's complement.
  // Offset 0x4F holds the right DAC offset trim code, two's complement.
  // Offset 0x55 holds the serial output source code in bits 4:0.
  // Bits 7:5 of offset 0x55 are reserved but kept as storage.
  // Every other offset reads as zero and ignores writes.
  // All registers clear to zero on reset.
  // A read and a write to one offset in one cycle return the old value.

  // ***************************************************************************
  // Decoding helpers
  // ***************************************************************************
  // Address match for one register; shared by the write decode of all four.
  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    addr_hit = (addr == offset);
  endfunction : addr_hit

  // Returns the stored byte, replaced by the write data on a write hit.
  // Each register decodes its own hit, so no write can spill into another.
  function automatic logic [7:0] write_field(
    input logic [7:0]        stored,
    input ddt_pkg::ddt_req_s req,
    input logic [7:0]        offset
  );
    if (req.wr && addr_hit(req.addr, offset))
    begin
      write_field = req.wdata;
    end
    else
    begin
      write_field = stored;
    end
  endfunction : write_field

  // Sign-extends a trim code by one bit.
  // Code 0x80 would overflow an 8-bit negation, hence the extra bit.
  function automatic logic signed [ddt_pkg::TRIM_WIDTH-1:0] sign_extend_trim(
    input logic [7:0] code
  );
    sign_extend_trim = {code[7], code};
  endfunction : sign_extend_trim

  // The trim is widened before negation so that code 0x80 maps to +128 steps.
  function automatic logic signed [ddt_pkg::TRIM_WIDTH-1:0] trim_to_qmv(
    input logic [7:0] code
  );
    logic signed [ddt_pkg::TRIM_WIDTH-1:0] wide;
    wide        = sign_extend_trim(code);
    trim_to_qmv = -wide;
  endfunction : trim_to_qmv

  // The code is carried unscaled; the modulator applies the 1/32 FS weight.
  function automatic logic [ddt_pkg::DITHER_WIDTH-1:0] dither_to_addend(
    input logic [7:0] code
  );
    dither_to_addend = {3'b000, code};
  endfunction : dither_to_addend

  // Picks the source code field out of the stored selection byte.
  function automatic logic [ddt_pkg::PIN_SOURCE_WIDTH-1:0] pin_source_field(
    input logic [7:0] stored
  );
    pin_source_field = stored[ddt_pkg::PIN_SOURCE_LSB +: ddt_pkg::PIN_SOURCE_WIDTH];
  endfunction : pin_source_field

  // Read data multiplexer.
  // Unmapped offsets return a fixed value rather than stale data.
  function automatic logic [7:0] read_mux(
    input ddt_pkg::ddt_state_s st,
    input logic [7:0]          addr
  );
    case (addr)
      ddt_pkg::OFS_RIGHT_SECONDARY_DC_DITHER:
      begin
        read_mux = st.dither;
      end
      ddt_pkg::OFS_LEFT_DC_OFFSET_TRIM:
      begin
        read_mux = st.left_trim;
      end
      ddt_pkg::OFS_RIGHT_DC_OFFSET_TRIM:
      begin
        read_mux = st.right_trim;
      end
      ddt_pkg::OFS_SERIAL_OUT_PIN_SOURCE_SEL:
      begin
        read_mux = st.pin_source;
      end
      default:
      begin
        read_mux = ddt_pkg::UNMAPPED_READ;
      end
    endcase
  endfunction : read_mux

  // ***************************************************************************
  // State registers
  // ***************************************************************************
  ddt_pkg::ddt_state_s state;
  ddt_pkg::ddt_state_s next_state;

  // ***************************************************************************
  // Next-state logic
  // ***************************************************************************
  always_comb
  begin
    next_state = state;

    // Register writes; an unmapped offset leaves every register untouched.
    next_state.dither = write_field(
      state.dither,
      REG_REQ,
      ddt_pkg::OFS_RIGHT_SECONDARY_DC_DITHER
    );

    next_state.left_trim = write_field(
      state.left_trim,
      REG_REQ,
      ddt_pkg::OFS_LEFT_DC_OFFSET_TRIM
    );

    next_state.right_trim = write_field(
      state.right_trim,
      REG_REQ,
      ddt_pkg::OFS_RIGHT_DC_OFFSET_TRIM
    );

    // Reserved bits 7:5 are kept as plain storage so that they read back.
    next_state.pin_source = write_field(
      state.pin_source,
      REG_REQ,
      ddt_pkg::OFS_SERIAL_OUT_PIN_SOURCE_SEL
    );

    // A read returns the stored value before any write in the same cycle.
    if (REG_REQ.rd)
    begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = read_mux(state, REG_REQ.addr);
    end
    else
    begin
      next_state.rvalid = 1'b0;
      next_state.rdata  = 8'h00;
    end

    // The derived values follow the stored codes one edge later, which keeps
    // the negation off the path from the register port.
    next_state.dither_addend = dither_to_addend(state.dither);
    next_state.left_offset   = trim_to_qmv(state.left_trim);
    next_state.right_offset  = trim_to_qmv(state.right_trim);
  end

  // ***************************************************************************
  // Register stage
  // ***************************************************************************
  // Reset loads constants only, so the derived outputs start at zero as well.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= ddt_pkg::STATE_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ***************************************************************************
  // Configuration outputs
  // ***************************************************************************
  // Only a secondary lower-path port exists, so the primary path cannot see it.
  assign RIGHT_SEC_LOWER_DITHER = state.dither_addend;
  assign LEFT_OFFSET_QMV        = state.left_offset;
  assign RIGHT_OFFSET_QMV       = state.right_offset;
  assign SERIAL_OUT_SOURCE_SEL  = pin_source_field(state.pin_source);

  // ***************************************************************************
  // Read port outputs
  // ***************************************************************************
  // Read data is zero between reads, so several banks can share one OR tree.
  assign REG_RDATA              = state.rdata;
  assign REG_RVALID             = state.rvalid;

endmodule : ddt_regs

// ---- sim/ddt_regs_chk.sv ----
// Checker for the dither and offset trim register bank.
// Assumes it is bound into ddt_regs and sees only that module's ports.
`timescale 1ns/1ps
module ddt_regs_chk (
  input wire logic              REF_CLK,
  input wire logic              RST_N,
  input wire ddt_pkg::ddt_req_s REG_REQ,
  input wire logic [10:0]       RIGHT_SEC_LOWER_DITHER,
  input wire logic signed [8:0] LEFT_OFFSET_QMV,
  input wire logic signed [8:0] RIGHT_OFFSET_QMV
);
  // ****
  // Properties
  // ****
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Two cycles, since the derived outputs trail the register by one edge.
  property p_dith; REG_REQ.wr && REG_REQ.addr == 8'h4C |-> ##2
    RIGHT_SEC_LOWER_DITHER == {3'h0, $past(REG_REQ.wdata, 2)}; endproperty
  a_dith: assert property (p_dith) else $error("dither value wrong");
  property p_top; RIGHT_SEC_LOWER_DITHER[10:8] == 3'h0; endproperty
  a_top: assert property (p_top) else $error("dither out of scale");
  property p_only; !$stable(RIGHT_SEC_LOWER_DITHER) |->
    $past(REG_REQ.wr, 2) && $past(REG_REQ.addr, 2) == 8'h4C; endproperty
  a_only: assert property (p_only) else $error("dither moved alone");
  property p_left; REG_REQ.wr && REG_REQ.addr == 8'h4E |-> ##2
    LEFT_OFFSET_QMV + $signed($past(REG_REQ.wdata, 2)) == 0; endproperty
  a_left: assert property (p_left) else $error("left offset wrong");
  property p_right; REG_REQ.wr && REG_REQ.addr == 8'h4F |-> ##2
    RIGHT_OFFSET_QMV + $signed($past(REG_REQ.wdata, 2)) == 0; endproperty
  a_right: assert property (p_right) else $error("right offset wrong");
  property p_rng; LEFT_OFFSET_QMV >= -9'sd127 && LEFT_OFFSET_QMV <= 9'sd128
    && RIGHT_OFFSET_QMV >= -9'sd127 && RIGHT_OFFSET_QMV <= 9'sd128; endproperty
  a_rng: assert property (p_rng) else $error("offset out of range");
endmodule : ddt_regs_chk
bind ddt_regs ddt_regs_chk u_chk (.REF_CLK, .RST_N, .REG_REQ, .RIGHT_SEC_LOWER_DITHER,
  .LEFT_OFFSET_QMV, .RIGHT_OFFSET_QMV);

// ---- sim/ddt_regs_test.sv ----
// Self-checking bench for the dither and offset trim register bank.
// Assumes the checker is bound in; the bench drives the strobe port itself.
`timescale 1ns/1ps
module ddt_regs_test;
  logic              ref_clk    = 1'b0;
  logic              rst_n      = 1'b0;
  ddt_pkg::ddt_req_s req        = '0;
  logic [7:0]        rdata;
  logic              rvalid;
  logic [10:0]       dith;
  logic [8:0]        lofs;
  logic [8:0]        rofs;
  logic [4:0]        sel;
  int                fail_count = 0;
  int                n_tests    = 0;
  initial forever #4 ref_clk = ~ref_clk;
  ddt_regs dut (.REF_CLK(ref_clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .RIGHT_SEC_LOWER_DITHER(dith), .LEFT_OFFSET_QMV(lofs),
    .RIGHT_OFFSET_QMV(rofs), .SERIAL_OUT_SOURCE_SEL(sel));
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [10:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  // The extra edge lets the derived outputs settle before anyone looks.
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) req <= '0;
    @(posedge ref_clk) #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk) req <= '0;
    #1 chk({2'h0, rvalid, rdata}, {3'h1, e});
  endtask : rd
  task automatic t_trim;
    logic [7:0] c [4] = '{8'h7F, 8'h80, 8'hFF, 8'h00};
    logic [8:0] q [4] = '{9'h181, 9'h080, 9'h001, 9'h000};
    rd(8'h4E, 8'h00);
    rd(8'h4F, 8'h00);
    foreach (c[i])
    begin
      wr(8'h4E, c[i]);
      chk(lofs, q[i]);
      wr(8'h4F, c[i]);
      chk(rofs, q[i]);
      rd(8'h4E, c[i]);
    end
    $display("trim test done");
  endtask : t_trim
  task automatic t_dith;
    rd(8'h4C, 8'h00);
    wr(8'h4C, 8'h01);
    chk(dith, 11'h001);
    wr(8'h4C, 8'hFF);
    chk(dith, 11'h0FF);
    wr(8'h4D, 8'hAA);
    rd(8'h4D, 8'h00);
    wr(8'h55, 8'hFF);
    chk(sel, 11'h01F);
    chk(dith, 11'h0FF);
    rd(8'h55, 8'hFF);
    wr(8'h4C, 8'h00);
    chk(dith, 11'h000);
    $display("dither test done");
  endtask : t_dith
  // A reset in mid-run must clear the codes and the derived outputs alike.
  task automatic t_reset;
    wr(8'h4C, 8'h5A);
    wr(8'h4E, 8'h10);
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk(dith, 11'h000);
    chk(lofs, 11'h000);
    rd(8'h4C, 8'h00);
    rd(8'h4E, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_trim();
    t_dith();
    t_reset();
    results();
  end
endmodule : ddt_regs_test
